/* File: mfm_defines.vh */
`ifndef MFM_DEFINES_VH
`define MFM_DEFINES_VH

// Class letters
`define MFM_CLS_NONE  2'd0
`define MFM_CLS_F     2'd1
`define MFM_CLS_E     2'd2
`define MFM_CLS_U     2'd3

// Recovery classes
`define MFM_REC_NONE  2'd0
`define MFM_REC_AUTO  2'd1
`define MFM_REC_ACK   2'd2
`define MFM_REC_LOCK  2'd3

// Fault numbers
`define MFM_N_E10 7'd10
`define MFM_N_E11 7'd11
`define MFM_N_E14 7'd14
`define MFM_N_E15 7'd15
`define MFM_N_E16 7'd16
`define MFM_N_E39 7'd39
`define MFM_N_E40 7'd40
`define MFM_N_E42 7'd42
`define MFM_N_E80 7'd80
`define MFM_N_E87 7'd87
`define MFM_N_E89 7'd89
`define MFM_N_E97 7'd97
`define MFM_N_U10 7'd10
`define MFM_N_U30 7'd30
`define MFM_N_U31 7'd31
`define MFM_N_U32 7'd32
`define MFM_N_U33 7'd33
`define MFM_N_U34 7'd34
`define MFM_N_U35 7'd35
`define MFM_N_U41 7'd41
`define MFM_N_U43 7'd43
`define MFM_N_U44 7'd44
`define MFM_N_U45 7'd45
`define MFM_N_U46 7'd46
`define MFM_N_U47 7'd47
`define MFM_N_U48 7'd48
`define MFM_N_U49 7'd49
`define MFM_N_U50 7'd50
`define MFM_N_U51 7'd51
`define MFM_N_U52 7'd52
`define MFM_N_U55 7'd55
`define MFM_N_U56 7'd56
`define MFM_N_U58 7'd58
`define MFM_N_U59 7'd59

// Timing
`define MFM_CLK_HZ        100000000
`define MFM_CONC_S        4
`define MFM_DISP_MS       500
`define MFM_OSC_LIMIT     4'd8
`define MFM_TOGGLE_LIMIT  3'd3

`endif

/* File: mfm_field.sv */
`timescale 1ns/1ns
module mfm_field (
  input  wire       clk,
  input  wire [3:0] sens_req,
  input  wire       ack_req,
  output reg  [3:0] sensor,
  output reg        ack_press
);
  initial sensor = 4'h0;
  initial ack_press = 1'b0;
  // Operator side needs one cycle to react
  always @(posedge clk) begin
    sensor    <= sens_req;
    ack_press <= ack_req;
  end
endmodule // mfm_field

/* File: mfm_monitor.v */
// How it works
// - Display alternates class letter and two-digit number
// - Unknown-source output fault E10/E11, auto reset
// - Under 16 V and over 31 V, auto
// - Over 40 V is locking E16
// - Acknowledge held too long, local/cabinet, auto
// - Muting enable too long, cleared by acknowledge
// - Outputs not switching together lock E97
// - Invalid host command flagged U10, auto
// - Adjacent sensor order errors, six codes
// - Clearing order errors per set, both directions
// - Second muting signal within 4 s
// - Muting end with field interrupted U43
// - Restart refused without valid sensors U50
// - Field violated, single signal U51
// - Override time limit exceeded U55
// - Acknowledge with field broken, no sensor
// - Muting timeout raises fault, acknowledge recovers
`timescale 1ns/1ns
`include "mfm_defines.vh"

module mfm_monitor #(
  parameter CONC_CYCLES = `MFM_CONC_S * `MFM_CLK_HZ,
  parameter DISP_CYCLES = (`MFM_DISP_MS * (`MFM_CLK_HZ / 1000))
) (
  input  wire       CLK_SYS,
  input  wire       RST,
  input  wire       OUT_FAULT_A,
  input  wire       OUT_FAULT_B,
  input  wire       UNDER_16V,
  input  wire       OVER_31V,
  input  wire       OVER_40V,
  input  wire       ACK_LOCAL_LONG,
  input  wire       ACK_CABINET_LONG,
  input  wire       ENABLE_TOO_LONG,
  input  wire       ACK_PRESS,
  input  wire       MODE_INVALID,
  input  wire [3:0] MODE_SEL,
  input  wire [7:0] SWITCH_POS,
  input  wire       OUTPUT_MISMATCH,
  input  wire       CMD_INVALID,
  input  wire [3:0] SENSOR,
  input  wire       FIELD_BROKEN,
  input  wire       MUTING_ACTIVE,
  input  wire       RESTART_REQ,
  input  wire       OVERRIDE_EXPIRED,
  input  wire       MUTING_TIMEOUT,
  input  wire       PERMIT,
  output reg        SAFETY_OUTPUT_A,
  output reg        SAFETY_OUTPUT_B,
  output reg        FAULT_ACTIVE,
  output reg  [1:0] FAULT_CLASS,
  output reg  [6:0] FAULT_NUM,
  output reg  [1:0] FAULT_RECOVERY,
  output reg        SHOW_LETTER,
  output reg  [1:0] DISP_CLASS,
  output reg  [6:0] DISP_NUM
);

  reg        running;
  reg  [3:0] mode_ref;
  reg  [7:0] sw_ref;
  reg        lock_flag;
  reg  [1:0] lock_cls;
  reg  [6:0] lock_num;
  reg        ack_flag;
  reg  [6:0] ack_num;
  reg  [3:0] sens_q;
  reg        muting_q;
  reg  [31:0] conc_cnt;
  reg        conc_run;
  reg        conc_err;
  reg  [31:0] disp_cnt;
  reg        u10_flag;

  wire [3:0] rise = SENSOR & ~sens_q;
  wire [3:0] fall = ~SENSOR & sens_q;
  wire [3:0] osc_hit;
  wire [3:0] tog_hit;

  // Per-sensor oscillation and toggle counters
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sens
      reg [3:0] osc_cnt;
      reg [2:0] tog_cnt;
      always @(posedge CLK_SYS) begin
        if (RST || MUTING_ACTIVE) begin
          osc_cnt <= 4'd0;
          tog_cnt <= 3'd0;
        end else begin
          if (rise[g] || fall[g]) begin
            if (osc_cnt != `MFM_OSC_LIMIT)
              osc_cnt <= osc_cnt + 4'd1;
          end else if (!SENSOR[g]) begin
            osc_cnt <= 4'd0;
          end
          if (fall[g] && tog_cnt != `MFM_TOGGLE_LIMIT)
            tog_cnt <= tog_cnt + 3'd1;
        end
      end
      assign osc_hit[g] = (osc_cnt == `MFM_OSC_LIMIT);
      assign tog_hit[g] = (tog_cnt == `MFM_TOGGLE_LIMIT);
    end
  endgenerate

  // Fault priority: lock, acknowledge class, then automatic
  reg       next_lock;
  reg [1:0] next_lcls;
  reg [6:0] next_lnum;
  reg       next_ack;
  reg [6:0] next_anum;
  reg       auto_on;
  reg [1:0] auto_cls;
  reg [6:0] auto_num;
  reg       u10_now;

  always @* begin
    next_lock = 1'b0;
    next_lcls = `MFM_CLS_E;
    next_lnum = 7'd0;
    if (OVER_40V) begin
      next_lock = 1'b1;
      next_lnum = `MFM_N_E16;
    end else if (MODE_INVALID) begin
      next_lock = 1'b1;
      next_lnum = `MFM_N_E80;
    end else if (running && MODE_SEL != mode_ref) begin
      next_lock = 1'b1;
      next_lnum = `MFM_N_E87;
    end else if (running && SWITCH_POS != sw_ref) begin
      next_lock = 1'b1;
      next_lnum = `MFM_N_E89;
    end else if (OUTPUT_MISMATCH) begin
      next_lock = 1'b1;
      next_lnum = `MFM_N_E97;
    end
    next_ack = 1'b0;
    next_anum = 7'd0;
    if (ENABLE_TOO_LONG) begin
      next_ack = 1'b1;
      next_anum = `MFM_N_E42;
    end else if (MUTING_TIMEOUT) begin
      next_ack = 1'b1;
      next_anum = `MFM_N_U58;
    end
    u10_now = CMD_INVALID;
    auto_on = 1'b1;
    auto_cls = `MFM_CLS_E;
    auto_num = 7'd0;
    if (OUT_FAULT_A)
      auto_num = `MFM_N_E10;
    else if (OUT_FAULT_B)
      auto_num = `MFM_N_E11;
    else if (UNDER_16V)
      auto_num = `MFM_N_E14;
    else if (OVER_31V)
      auto_num = `MFM_N_E15;
    else if (ACK_LOCAL_LONG)
      auto_num = `MFM_N_E39;
    else if (ACK_CABINET_LONG)
      auto_num = `MFM_N_E40;
    else begin
      auto_cls = `MFM_CLS_U;
      if (u10_flag)
        auto_num = `MFM_N_U10;
      else if (rise[1] && sens_q == 4'b0000)
        auto_num = `MFM_N_U30;
      else if (rise[2] && sens_q == 4'b0001)
        auto_num = `MFM_N_U31;
      else if (rise[3] && sens_q == 4'b0010)
        auto_num = `MFM_N_U32;
      else if (rise[0] && sens_q == 4'b0010)
        auto_num = `MFM_N_U47;
      else if (rise[1] && sens_q == 4'b0100)
        auto_num = `MFM_N_U48;
      else if (rise[2] && sens_q == 4'b1000)
        auto_num = `MFM_N_U49;
      else if (sens_q == 4'b1111 && (fall & 4'b1110) != 4'b0000)
        auto_num = `MFM_N_U33;
      else if (sens_q == 4'b1110 && (fall & 4'b1100) != 4'b0000)
        auto_num = `MFM_N_U34;
      else if (sens_q == 4'b1100 && fall[3])
        auto_num = `MFM_N_U35;
      else if (sens_q == 4'b0011 && fall[0])
        auto_num = `MFM_N_U44;
      else if (sens_q == 4'b0111 && (fall & 4'b0011) != 4'b0000)
        auto_num = `MFM_N_U45;
      else if (sens_q == 4'b1111 && fall[0] && SENSOR[3])
        auto_num = `MFM_N_U46;
      else if (conc_err)
        auto_num = `MFM_N_U41;
      else if (muting_q && !MUTING_ACTIVE && FIELD_BROKEN)
        auto_num = `MFM_N_U43;
      else if (RESTART_REQ && SENSOR[1:0] != 2'b11)
        auto_num = `MFM_N_U50;
      else if (FIELD_BROKEN && !MUTING_ACTIVE &&
               (SENSOR[0] ^ SENSOR[1]))
        auto_num = `MFM_N_U51;
      else if (|osc_hit)
        auto_num = `MFM_N_U52;
      else if (OVERRIDE_EXPIRED)
        auto_num = `MFM_N_U55;
      else if (ACK_PRESS && FIELD_BROKEN && SENSOR == 4'b0000)
        auto_num = `MFM_N_U56;
      else if (|tog_hit)
        auto_num = `MFM_N_U59;
      else
        auto_on = 1'b0;
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      running <= 1'b0;
      mode_ref <= 4'h0;
      sw_ref <= 8'h00;
      lock_flag <= 1'b0;
      lock_cls <= `MFM_CLS_NONE;
      lock_num <= 7'd0;
      ack_flag <= 1'b0;
      ack_num <= 7'd0;
      sens_q <= 4'h0;
      muting_q <= 1'b0;
      conc_cnt <= 32'h0;
      conc_run <= 1'b0;
      conc_err <= 1'b0;
      u10_flag <= 1'b0;
    end else begin
      // Configuration captured once, after reset release
      running <= 1'b1;
      if (!running) begin
        mode_ref <= MODE_SEL;
        sw_ref <= SWITCH_POS;
      end
      sens_q <= SENSOR;
      muting_q <= MUTING_ACTIVE;
      u10_flag <= u10_now;
      if (next_lock && !lock_flag) begin
        lock_flag <= 1'b1;
        lock_cls <= next_lcls;
        lock_num <= next_lnum;
      end
      // A new cause wins over an acknowledge in the same cycle
      if (next_ack) begin
        ack_flag <= 1'b1;
        ack_num <= next_anum;
      end else if (ACK_PRESS) begin
        ack_flag <= 1'b0;
      end
      if (SENSOR[1:0] == 2'b00 || SENSOR[1:0] == 2'b11) begin
        conc_run <= 1'b0;
        conc_cnt <= 32'h0;
        if (SENSOR[1:0] == 2'b00)
          conc_err <= 1'b0;
      end else if (!conc_run) begin
        conc_run <= 1'b1;
        conc_cnt <= 32'h0;
      end else if (conc_cnt == CONC_CYCLES - 1) begin
        conc_err <= 1'b1;
      end else begin
        conc_cnt <= conc_cnt + 32'h1;
      end
    end
  end

  // Outputs and alternating display
  always @(posedge CLK_SYS) begin
    if (RST) begin
      SAFETY_OUTPUT_A <= 1'b0;
      SAFETY_OUTPUT_B <= 1'b0;
      FAULT_ACTIVE <= 1'b0;
      FAULT_CLASS <= `MFM_CLS_NONE;
      FAULT_NUM <= 7'd0;
      FAULT_RECOVERY <= `MFM_REC_NONE;
      SHOW_LETTER <= 1'b1;
      DISP_CLASS <= `MFM_CLS_NONE;
      DISP_NUM <= 7'd0;
      disp_cnt <= 32'h0;
    end else begin
      FAULT_ACTIVE <= lock_flag | ack_flag | auto_on;
      if (lock_flag) begin
        FAULT_CLASS <= lock_cls;
        FAULT_NUM <= lock_num;
        FAULT_RECOVERY <= `MFM_REC_LOCK;
      end else if (ack_flag) begin
        FAULT_CLASS <= (ack_num == `MFM_N_U58) ? `MFM_CLS_U : `MFM_CLS_E;
        FAULT_NUM <= ack_num;
        FAULT_RECOVERY <= `MFM_REC_ACK;
      end else if (auto_on) begin
        FAULT_CLASS <= auto_cls;
        FAULT_NUM <= auto_num;
        FAULT_RECOVERY <= `MFM_REC_AUTO;
      end else begin
        FAULT_CLASS <= `MFM_CLS_NONE;
        FAULT_NUM <= 7'd0;
        FAULT_RECOVERY <= `MFM_REC_NONE;
      end
      // Any fault class forces both outputs off
      SAFETY_OUTPUT_A <= PERMIT & ~(lock_flag | ack_flag | auto_on);
      SAFETY_OUTPUT_B <= PERMIT & ~(lock_flag | ack_flag | auto_on);
      if (disp_cnt == DISP_CYCLES - 1) begin
        disp_cnt <= 32'h0;
        SHOW_LETTER <= ~SHOW_LETTER;
      end else begin
        disp_cnt <= disp_cnt + 32'h1;
      end
      DISP_CLASS <= FAULT_CLASS;
      DISP_NUM <= FAULT_NUM;
    end
  end

endmodule // mfm_monitor

/* File: mfm_monitor_sva.sv */
`timescale 1ns/1ns
module mfm_chk #(
  parameter CONC_CYCLES = 20,
  parameter DISP_CYCLES = 4
) (
  input wire       CLK_SYS,
  input wire       RST,
  input wire       UNDER_16V,
  input wire       OVER_40V,
  input wire       ENABLE_TOO_LONG,
  input wire       OUTPUT_MISMATCH,
  input wire       CMD_INVALID,
  input wire       MUTING_TIMEOUT,
  input wire       SAFETY_OUTPUT_A,
  input wire       SAFETY_OUTPUT_B,
  input wire       FAULT_ACTIVE,
  input wire [6:0] FAULT_NUM,
  input wire [1:0] FAULT_CLASS,
  input wire [1:0] FAULT_RECOVERY,
  input wire       SHOW_LETTER,
  input wire [1:0] DISP_CLASS,
  input wire [6:0] DISP_NUM
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // Cycles since the letter/number phase last flipped
  reg        sl_q;
  reg [31:0] sl_run;
  always @(posedge CLK_SYS) begin
    sl_q <= SHOW_LETTER;
    if (RST || SHOW_LETTER != sl_q)
      sl_run <= 32'h0;
    else
      sl_run <= sl_run + 32'h1;
  end
  a_letter_pace: assert property (sl_run <= DISP_CYCLES)
    else $error("display phase did not alternate");
  a_disp_class: assert property (1'b1 |=> DISP_CLASS == $past(FAULT_CLASS))
    else $error("display class lags wrongly");
  sequence s_locked;
    FAULT_RECOVERY == 2'd3 && !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B;
  endsequence
  a_lock_over: assert property (OVER_40V |-> ##2 s_locked)
    else $error("overvoltage lock missing");
  a_lock_keep: assert property (FAULT_RECOVERY == 2'd3 |=> s_locked)
    else $error("lock released without reset");
  a_link_lock: assert property (OUTPUT_MISMATCH |-> ##2 s_locked)
    else $error("output mismatch not locked");
  a_out_off: assert property (FAULT_ACTIVE |-> !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B)
    else $error("outputs on during fault");
  a_under_flag: assert property (UNDER_16V |=> FAULT_ACTIVE)
    else $error("undervoltage not flagged");
  a_enable_long: assert property (ENABLE_TOO_LONG |-> ##2 FAULT_ACTIVE)
    else $error("enable timeout not flagged");
  a_cmd_flag: assert property (CMD_INVALID |-> ##2 FAULT_ACTIVE)
    else $error("invalid command not flagged");
  a_mute_tmo: assert property (MUTING_TIMEOUT |-> ##2 FAULT_ACTIVE)
    else $error("muting timeout not flagged");
  a_disp_copy: assert property (1'b1 |=> DISP_NUM == $past(FAULT_NUM))
    else $error("display number lags wrongly");
endmodule // mfm_chk

bind mfm_monitor mfm_chk #(.CONC_CYCLES(CONC_CYCLES),
  .DISP_CYCLES(DISP_CYCLES)) u_chk (.CLK_SYS(CLK_SYS), .RST(RST),
  .UNDER_16V(UNDER_16V), .OVER_40V(OVER_40V),
  .ENABLE_TOO_LONG(ENABLE_TOO_LONG), .OUTPUT_MISMATCH(OUTPUT_MISMATCH),
  .CMD_INVALID(CMD_INVALID), .MUTING_TIMEOUT(MUTING_TIMEOUT),
  .SAFETY_OUTPUT_A(SAFETY_OUTPUT_A), .SAFETY_OUTPUT_B(SAFETY_OUTPUT_B),
  .FAULT_ACTIVE(FAULT_ACTIVE), .FAULT_NUM(FAULT_NUM),
  .FAULT_CLASS(FAULT_CLASS), .FAULT_RECOVERY(FAULT_RECOVERY),
  .SHOW_LETTER(SHOW_LETTER), .DISP_CLASS(DISP_CLASS),
  .DISP_NUM(DISP_NUM));

/* File: testbench.sv */
`timescale 1ns/1ns
`include "mfm_defines.vh"
module testbench;
  reg          clk_sys = 1'b0;
  reg          rst = 1'b1;
  reg   [5:0]  ea = 6'h00;
  reg   [2:0]  lk = 3'h0;
  reg   [3:0]  mode = 4'h1;
  reg   [7:0]  sw = 8'h5a;
  reg   [6:0]  misc = 7'h00;
  reg   [3:0]  sens_req = 4'h0;
  reg          ack_req = 1'b0;
  wire  [3:0]  sensor;
  wire         ack_press, sa, sb, fa, sl;
  wire  [1:0]  fc, fr, dc;
  wire  [6:0]  fn, dn;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cnt = 0;
  int          due_q[$];
  logic [13:0] exp_q[$];
  logic [13:0] v;
  logic [6:0]  en[6] = '{`MFM_N_E10, `MFM_N_E11, `MFM_N_E14, `MFM_N_E15,
                         `MFM_N_E39, `MFM_N_E40};
  logic [6:0]  un[3] = '{`MFM_N_U10, `MFM_N_U50, `MFM_N_U55};
  logic [6:0]  ln[5] = '{`MFM_N_E16, `MFM_N_E80, `MFM_N_E97, `MFM_N_E87,
                         `MFM_N_E89};
  localparam logic [13:0] IDLE = 14'h3000;

  always #5 clk_sys = ~clk_sys;

  mfm_field u_field (.clk(clk_sys), .sens_req(sens_req), .ack_req(ack_req),
    .sensor(sensor), .ack_press(ack_press));
  mfm_monitor #(.CONC_CYCLES(20), .DISP_CYCLES(4)) DUT (.CLK_SYS(clk_sys),
    .RST(rst), .OUT_FAULT_A(ea[0]), .OUT_FAULT_B(ea[1]), .UNDER_16V(ea[2]),
    .OVER_31V(ea[3]), .OVER_40V(lk[0]), .ACK_LOCAL_LONG(ea[4]),
    .ACK_CABINET_LONG(ea[5]), .ENABLE_TOO_LONG(misc[0]),
    .ACK_PRESS(ack_press), .MODE_INVALID(lk[1]), .MODE_SEL(mode),
    .SWITCH_POS(sw), .OUTPUT_MISMATCH(lk[2]), .CMD_INVALID(misc[1]),
    .SENSOR(sensor), .FIELD_BROKEN(misc[5]), .MUTING_ACTIVE(misc[6]),
    .RESTART_REQ(misc[2]), .OVERRIDE_EXPIRED(misc[3]),
    .MUTING_TIMEOUT(misc[4]), .PERMIT(1'b1), .SAFETY_OUTPUT_A(sa),
    .SAFETY_OUTPUT_B(sb), .FAULT_ACTIVE(fa), .FAULT_CLASS(fc),
    .FAULT_NUM(fn), .FAULT_RECOVERY(fr), .SHOW_LETTER(sl),
    .DISP_CLASS(dc), .DISP_NUM(dn));

  task automatic cmp(input logic [13:0] e, input logic [13:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD fault_state exp %h got %h", e, g);
    end
  endtask
  // Due stamps in queue order, so only the head is ever compared
  task automatic note(input int lat, input logic [13:0] e);
    due_q.push_back(cnt + lat);
    exp_q.push_back(e);
  endtask
  function automatic logic [13:0] fv(input logic [1:0] c,
                                     input logic [6:0] n,
                                     input logic [1:0] r);
    return {3'b001, c, n, r};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic do_reset;
    @(posedge clk_sys) rst <= 1'b1;
    tick(4);
    rst <= 1'b0;
    tick(3);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Counter moves on the falling edge so drivers read a settled value
  always @(negedge clk_sys) begin
    if (due_q.size() > 0 && due_q[0] == cnt) begin
      cmp(exp_q[0], {sa, sb, fa, fc, fn, fr});
      void'(due_q.pop_front());
      void'(exp_q.pop_front());
    end
    cnt <= cnt + 1;
  end

  initial begin
    #50000;
    n_fail++;
    give_verdict;
  end

  initial begin
    void'($urandom(44));
    do_reset;
    note(1, IDLE);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_sys) ea[i] <= 1'b1;
      note(1, fv(2'd2, en[i], 2'd1));
      tick(2 + $urandom % 4);
      ea[i] <= 1'b0;
      note(1, IDLE);
      tick(2);
    end
    $display("auto supply and output faults done");
    for (int j = 0; j < 2; j++) begin
      v = j ? fv(2'd3, `MFM_N_U58, 2'd2) : fv(2'd2, `MFM_N_E42, 2'd2);
      @(posedge clk_sys) misc[j*4] <= 1'b1;
      note(2, v);
      @(posedge clk_sys) misc[j*4] <= 1'b0;
      note(6, v);
      tick(8);
      ack_req <= 1'b1;
      tick(3);
      ack_req <= 1'b0;
      note(6, IDLE);
      tick(8);
    end
    $display("acknowledge faults done");
    for (int j = 0; j < 3; j++) begin
      @(posedge clk_sys) misc[j+1] <= 1'b1;
      // Host command fault is registered once more before it shows
      note(j == 0 ? 2 : 1, fv(2'd3, un[j], 2'd1));
      @(posedge clk_sys) misc[j+1] <= 1'b0;
      note(j == 0 ? 2 : 1, IDLE);
      tick(3);
    end
    @(posedge clk_sys) sens_req <= 4'h1;
    note(26, fv(2'd3, `MFM_N_U41, 2'd1));
    tick(28);
    sens_req <= 4'h0;
    note(6, IDLE);
    tick(8);
    $display("usage faults done");
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys);
      if (k < 3)
        lk[k] <= 1'b1;
      else if (k == 3)
        mode <= mode + 4'h1;
      else
        sw <= sw ^ 8'($urandom_range(1, 255));
      note(2, fv(2'd2, ln[k], 2'd3));
      @(posedge clk_sys) lk <= 3'h0;
      note(8, fv(2'd2, ln[k], 2'd3));
      tick(10);
      do_reset;
      note(1, IDLE);
      tick(3);
    end
    $display("locking faults done");
    @(posedge clk_sys) sens_req <= 4'h2;
    note(2, fv(2'd3, `MFM_N_U30, 2'd1));
    note(3, IDLE);
    tick(2);
    sens_req <= 4'h0;
    tick(3);
    @(posedge clk_sys) begin
      misc[5] <= 1'b1;
      sens_req <= 4'h1;
    end
    note(2, fv(2'd3, `MFM_N_U51, 2'd1));
    tick(3);
    misc[5] <= 1'b0;
    sens_req <= 4'h0;
    note(1, IDLE);
    tick(3);
    @(posedge clk_sys) begin
      misc[5] <= 1'b1;
      ack_req <= 1'b1;
    end
    note(2, fv(2'd3, `MFM_N_U56, 2'd1));
    @(posedge clk_sys) ack_req <= 1'b0;
    note(2, IDLE);
    tick(2);
    misc[5] <= 1'b0;
    @(posedge clk_sys) misc[6:5] <= 2'b11;
    @(posedge clk_sys) misc[6] <= 1'b0;
    note(1, fv(2'd3, `MFM_N_U43, 2'd1));
    note(2, IDLE);
    tick(1);
    misc[5] <= 1'b0;
    @(posedge clk_sys) sens_req <= 4'h1;
    @(posedge clk_sys) sens_req <= 4'h3;
    @(posedge clk_sys) sens_req <= 4'h2;
    note(2, fv(2'd3, `MFM_N_U44, 2'd1));
    note(3, IDLE);
    tick(2);
    sens_req <= 4'h0;
    tick(3);
    for (int t = 0; t < 8; t++)
      @(posedge clk_sys) sens_req <= sens_req ^ 4'h8;
    note(3, fv(2'd3, `MFM_N_U52, 2'd1));
    note(4, fv(2'd3, `MFM_N_U59, 2'd1));
    tick(4);
    misc[6] <= 1'b1;
    note(2, IDLE);
    tick(2);
    misc[6] <= 1'b0;
    tick(3);
    $display("sensor faults done");
    tick(4);
    give_verdict;
  end
endmodule // testbench
